// file: audio_control_three_regs.svh
// Register offsets, field positions and reset values of the audio control three register
//Operation
//- The two-bit volume-link field selects independent volumes (00 and 11), right copied to left (01) or left copied to right (10).
//- The reference-rate bit picks 48.0 kHz when 0 and 44.1 kHz when 1, steering de-emphasis, gain-control and converter clock settings.
//- The master transfer mode bit gives continuous transfer when 0 and 256-s transfer when 1.
//- The role-select bit makes the codec an audio slave when 0 and the clock master when 1.
//- The cellular-input bit makes the negative cellular input single-ended when 0 and differential when 1.
//- The cellular-output bit makes the positive cellular output single-ended when 0 and differential when 1.
//- The read-only record overflow flag goes to 1 when recorded converter data passes its saturation limits.
//- The read-only left playback overflow flag goes to 1 when left playback data passes its saturation limits.
//- The read-only right playback overflow flag goes to 1 when right playback data passes its saturation limits.
//- Each overflow flag returns to 0 after a host read of the register with no new saturation in the same cycle, so a set flag latches until such a read.
//- The clip-stepping bit enables microphone gain-control clip stepping when 1 and resets to 0.
//- Clip stepping acts only while automatic gain control is selected for the headset/auxiliary or handset input.
//- The lowest three bits return the read-only device revision identifier.
`ifndef AUDIO_CONTROL_THREE_REGS_SVH
`define AUDIO_CONTROL_THREE_REGS_SVH

`define AC3_OFFSET          7'h06
`define AC3_VOL_LINK_MSB    15
`define AC3_VOL_LINK_LSB    14
`define AC3_REF_RATE_BIT    13
`define AC3_XFER_MODE_BIT   12
`define AC3_ROLE_BIT        11
`define AC3_CELL_IN_BIT     10
`define AC3_CELL_OUT_BIT    9
`define AC3_REC_OVF_BIT     8
`define AC3_LEFT_OVF_BIT    7
`define AC3_RIGHT_OVF_BIT   6
`define AC3_RSVD_MSB        5
`define AC3_RSVD_LSB        4
`define AC3_CLIP_STEP_BIT   3
`define AC3_REV_MSB         2
`define AC3_REV_LSB         0
`define AC3_CTRL_RESET      10'h000
`define AC3_FLAGS_RESET     3'h0
`define AC3_REVISION        3'h1

`endif

// file: ac3_pkg.sv
// Types shared by the audio control three register logic
package ac3_pkg;

   typedef enum logic [1:0] {
      AC3_VOL_INDEPENDENT = 2'h0,
      AC3_VOL_RIGHT_TO_LEFT = 2'h1,
      AC3_VOL_LEFT_TO_RIGHT = 2'h2,
      AC3_VOL_SAME_AS_INDEP = 2'h3
   } ac3_vol_link_e;

   typedef struct packed {
      ac3_vol_link_e volume_link_mode;
      logic          reference_rate_select;
      logic          master_transfer_mode;
      logic          role_select;
      logic          cell_input_differential;
      logic          cell_output_differential;
      logic [1:0]    reserved;
      logic          clip_stepping_control;
   } ac3_ctrl_s;

   typedef struct packed {
      logic record_overflow_flag;
      logic left_play_overflow_flag;
      logic right_play_overflow_flag;
   } ac3_flags_s;

endpackage : ac3_pkg

// file: ac3_audio_control_three.sv
// Audio control three register: control fields, sticky overflow flags, revision
`timescale 1ns/1ns
`include "audio_control_three_regs.svh"

module ac3_audio_control_three
   import ac3_pkg::*;
#(
   parameter int          VOL_W    = 7,
   parameter logic [2:0]  REVISION = `AC3_REVISION // Arbitrary value
)(
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   input  wire logic              ce_i,
   // Register port from the serial control front end
   input  wire logic [6:0]        reg_addr_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   input  wire logic [15:0]       reg_wdata_i,
   output logic      [15:0]       reg_rdata_o,
   output logic                   reg_rvalid_o,
   // Datapath events and selects
   input  wire logic              record_sat_i,
   input  wire logic              left_play_sat_i,
   input  wire logic              right_play_sat_i,
   input  wire logic              agc_selected_i,
   input  wire logic [VOL_W-1:0]  left_vol_prog_i,
   input  wire logic [VOL_W-1:0]  right_vol_prog_i,
   // Control outputs
   output logic      [VOL_W-1:0]  left_vol_o,
   output logic      [VOL_W-1:0]  right_vol_o,
   output logic                   ref_rate_441_o,
   output logic                   xfer_256s_o,
   output logic                   master_o,
   output logic                   cell_negative_input_diff_o,
   output logic                   cell_positive_output_diff_o,
   output logic                   clip_step_active_o
);

   initial
   begin
      if (VOL_W < 1 || VOL_W > 16)
      begin
         $error("VOL_W must lie between 1 and 16");
      end
   end

   ac3_ctrl_s        ctrl;
   ac3_ctrl_s        next_ctrl;
   ac3_flags_s       flags;
   ac3_flags_s       next_flags;
   logic [15:0]      rdata;
   logic [15:0]      next_rdata;
   logic             rvalid;
   logic             next_rvalid;
   logic [VOL_W-1:0] left_vol;
   logic [VOL_W-1:0] next_left_vol;
   logic [VOL_W-1:0] right_vol;
   logic [VOL_W-1:0] next_right_vol;
   logic             clip_act;
   logic             next_clip_act;
   logic             hit;
   logic [15:0]      reg_image;

   assign hit = (reg_addr_i == `AC3_OFFSET);

   always_comb
   begin
      reg_image = 16'h0000;
      reg_image[`AC3_VOL_LINK_MSB:`AC3_VOL_LINK_LSB] = ctrl.volume_link_mode;
      reg_image[`AC3_REF_RATE_BIT]  = ctrl.reference_rate_select;
      reg_image[`AC3_XFER_MODE_BIT] = ctrl.master_transfer_mode;
      reg_image[`AC3_ROLE_BIT]      = ctrl.role_select;
      reg_image[`AC3_CELL_IN_BIT]   = ctrl.cell_input_differential;
      reg_image[`AC3_CELL_OUT_BIT]  = ctrl.cell_output_differential;
      reg_image[`AC3_REC_OVF_BIT]   = flags.record_overflow_flag;
      reg_image[`AC3_LEFT_OVF_BIT]  = flags.left_play_overflow_flag;
      reg_image[`AC3_RIGHT_OVF_BIT] = flags.right_play_overflow_flag;
      reg_image[`AC3_RSVD_MSB:`AC3_RSVD_LSB] = ctrl.reserved;
      reg_image[`AC3_CLIP_STEP_BIT] = ctrl.clip_stepping_control;
      reg_image[`AC3_REV_MSB:`AC3_REV_LSB] = REVISION;
   end

   // Register file next state
   always_comb
   begin
      next_ctrl   = ctrl;
      next_flags  = flags;
      next_rdata  = rdata;
      next_rvalid = 1'b0;
      if (reg_wr_i && hit)
      begin
         next_ctrl.volume_link_mode =
            ac3_vol_link_e'(reg_wdata_i[`AC3_VOL_LINK_MSB:`AC3_VOL_LINK_LSB]);
         next_ctrl.reference_rate_select    = reg_wdata_i[`AC3_REF_RATE_BIT];
         next_ctrl.master_transfer_mode     = reg_wdata_i[`AC3_XFER_MODE_BIT];
         next_ctrl.role_select              = reg_wdata_i[`AC3_ROLE_BIT];
         next_ctrl.cell_input_differential  = reg_wdata_i[`AC3_CELL_IN_BIT];
         next_ctrl.cell_output_differential = reg_wdata_i[`AC3_CELL_OUT_BIT];
         next_ctrl.reserved = reg_wdata_i[`AC3_RSVD_MSB:`AC3_RSVD_LSB];
         next_ctrl.clip_stepping_control    = reg_wdata_i[`AC3_CLIP_STEP_BIT];
      end
      if (reg_rd_i)
      begin
         next_rvalid = 1'b1;
         if (hit)
         begin
            next_rdata = reg_image;
            next_flags = `AC3_FLAGS_RESET;
         end
         else
         begin
            next_rdata = 16'h0000;
         end
      end
      // Set wins over the read clear
      if (record_sat_i)
      begin
         next_flags.record_overflow_flag = 1'b1;
      end
      if (left_play_sat_i)
      begin
         next_flags.left_play_overflow_flag = 1'b1;
      end
      if (right_play_sat_i)
      begin
         next_flags.right_play_overflow_flag = 1'b1;
      end
   end

   // Volume linking and clip stepping gate
   always_comb
   begin
      next_left_vol  = left_vol_prog_i;
      next_right_vol = right_vol_prog_i;
      case (ctrl.volume_link_mode)
         AC3_VOL_RIGHT_TO_LEFT:
         begin
            next_left_vol = right_vol_prog_i;
         end
         AC3_VOL_LEFT_TO_RIGHT:
         begin
            next_right_vol = left_vol_prog_i;
         end
         default:
         begin
            next_left_vol  = left_vol_prog_i;
            next_right_vol = right_vol_prog_i;
         end
      endcase
      next_clip_act = ctrl.clip_stepping_control & agc_selected_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         ctrl      <= `AC3_CTRL_RESET;
         flags     <= `AC3_FLAGS_RESET;
         rdata     <= 16'h0000;
         rvalid    <= 1'b0;
         left_vol  <= '0;
         right_vol <= '0;
         clip_act  <= 1'b0;
      end
      else if (ce_i)
      begin
         ctrl      <= next_ctrl;
         flags     <= next_flags;
         rdata     <= next_rdata;
         rvalid    <= next_rvalid;
         left_vol  <= next_left_vol;
         right_vol <= next_right_vol;
         clip_act  <= next_clip_act;
      end
   end

   assign reg_rdata_o                 = rdata;
   assign reg_rvalid_o                = rvalid;
   assign left_vol_o                  = left_vol;
   assign right_vol_o                 = right_vol;
   assign ref_rate_441_o              = ctrl.reference_rate_select;
   assign xfer_256s_o                 = ctrl.master_transfer_mode;
   assign master_o                    = ctrl.role_select;
   assign cell_negative_input_diff_o  = ctrl.cell_input_differential;
   assign cell_positive_output_diff_o = ctrl.cell_output_differential;
   assign clip_step_active_o          = clip_act;

endmodule : ac3_audio_control_three

// file: ac3_host_model.sv
// Host model driving the register port of the audio control three register
`timescale 1ns/1ns
module ac3_host_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] reg_rdata_i,
   input  wire logic        reg_rvalid_i,
   output logic      [6:0]  reg_addr_o,
   output logic             reg_wr_o,
   output logic             reg_rd_o,
   output logic      [15:0] reg_wdata_o
);
   initial
   begin
      reg_addr_o  = 7'h00;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_wdata_o = 16'h0000;
   end
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(negedge clk_i);
      reg_addr_o  = a;
      reg_wdata_o = d;
      reg_wr_o    = 1'b1;
      @(negedge clk_i);
      reg_wr_o    = 1'b0;
      reg_wdata_o = ~d;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic v);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_rd_o   = 1'b1;
      @(negedge clk_i);
      reg_rd_o   = 1'b0;
      reg_addr_o = ~a;
      d          = reg_rdata_i;
      v          = reg_rvalid_i;
   endtask : rd
endmodule : ac3_host_model

// file: ac3_audio_control_three_asserts.sv
// Checker of the audio control three register ports
`timescale 1ns/1ns
module ac3_audio_control_three_asserts #(
   parameter logic [2:0] REVISION = 3'h1
)(
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic        ce_i,
   input wire logic [6:0]  reg_addr_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic        reg_rvalid_o,
   input wire logic        record_sat_i,
   input wire logic        agc_selected_i,
   input wire logic        ref_rate_441_o,
   input wire logic        xfer_256s_o,
   input wire logic        master_o,
   input wire logic        cell_negative_input_diff_o,
   input wire logic        cell_positive_output_diff_o,
   input wire logic        clip_step_active_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);
   logic        wa;
   logic        ra;
   logic [15:0] wd_q;
   assign wa = ce_i && reg_wr_i && reg_addr_i == 7'h06;
   assign ra = ce_i && reg_rd_i && reg_addr_i == 7'h06;
   always_ff @(posedge clk_i) wd_q <= reg_wdata_i;
   AST_REV: assert property (ra |=> reg_rvalid_o && reg_rdata_o[2:0] == REVISION)
      else $error("revision read wrong");
   AST_REF: assert property (wa |=> ref_rate_441_o == wd_q[13])
      else $error("rate select wrong");
   AST_XFER: assert property (wa |=> xfer_256s_o == wd_q[12])
      else $error("transfer mode wrong");
   AST_ROLE: assert property (wa |=> master_o == wd_q[11])
      else $error("role wrong");
   AST_CIN: assert property (wa |=> cell_negative_input_diff_o == wd_q[10])
      else $error("cell input select wrong");
   AST_COUT: assert property (wa |=> cell_positive_output_diff_o == wd_q[9])
      else $error("cell output select wrong");
   AST_REC: assert property (ce_i && record_sat_i ##1 ra |=> reg_rdata_o[8])
      else $error("record flag not set");
   AST_CLEAR: assert property (ra && !record_sat_i ##1 ra |=> !reg_rdata_o[8])
      else $error("record flag not cleared");
   AST_CLIP: assert property (ce_i && !agc_selected_i |=> !clip_step_active_o)
      else $error("clip active without gain control");
endmodule : ac3_audio_control_three_asserts
bind ac3_audio_control_three ac3_audio_control_three_asserts #(.REVISION(REVISION)) ac3_asserts_i (.*);

// file: tb.sv
// Testbench of the audio control three register
`timescale 1ns/1ns
module tb;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        ce = 1'b1;
   logic        rec_sat = 1'b0;
   logic        left_sat = 1'b0;
   logic        right_sat = 1'b0;
   logic        agc = 1'b0;
   logic [6:0]  lprog = 7'h11;
   logic [6:0]  rprog = 7'h22;
   logic [6:0]  lvol;
   logic [6:0]  rvol;
   logic [6:0]  addr;
   logic        wr;
   logic        rd;
   logic        rvalid;
   logic        v;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [15:0] d;
   logic [4:0]  sel;
   logic        clip;
   int          errors = 0;
   int          checked = 0;
   always #5 clk = ~clk;
   ac3_host_model ac3_host_model_i (.clk_i(clk), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
      .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));
   ac3_audio_control_three #(.VOL_W(7), .REVISION(3'h5)) ac3_audio_control_three_i (.clk_i(clk),
      .reset_n_i(reset_n), .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .record_sat_i(rec_sat), .left_play_sat_i(left_sat),
      .right_play_sat_i(right_sat), .agc_selected_i(agc), .left_vol_prog_i(lprog), .right_vol_prog_i(rprog),
      .left_vol_o(lvol), .right_vol_o(rvol), .ref_rate_441_o(sel[4]), .xfer_256s_o(sel[3]), .master_o(sel[2]),
      .cell_negative_input_diff_o(sel[1]), .cell_positive_output_diff_o(sel[0]), .clip_step_active_o(clip));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
      ac3_host_model_i.rd(a, d, v);
      chk({15'h0, v}, 16'h0001);
      chk(d, exp);
   endtask : rdchk
   task automatic results;
      if (errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   initial
   begin
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      rdchk(7'h06, 16'h0005);
      ac3_host_model_i.wr(7'h06, 16'hffff);
      rdchk(7'h06, 16'hfe3d);
      chk({11'h0, sel}, 16'h001f);
      chk({15'h0, clip}, 16'h0000);
      agc = 1'b1;
      repeat (2) @(negedge clk);
      chk({15'h0, clip}, 16'h0001);
      ac3_host_model_i.wr(7'h07, 16'h0000);
      rdchk(7'h06, 16'hfe3d);
      rdchk(7'h05, 16'h0000);
      ce = 1'b0;
      ac3_host_model_i.wr(7'h06, 16'h0000);
      ce = 1'b1;
      rdchk(7'h06, 16'hfe3d);
      for (int m = 0; m < 4; m++)
      begin
         ac3_host_model_i.wr(7'h06, {m[1:0], 14'h0});
         @(negedge clk);
         chk({2'h0, lvol, rvol}, {2'h0, (m == 1) ? rprog : lprog, (m == 2) ? lprog : rprog});
      end
      chk({11'h0, sel}, 16'h0000);
      for (int i = 0; i < 3; i++)
      begin
         @(negedge clk);
         {rec_sat, left_sat, right_sat} = 3'h4 >> i;
         @(negedge clk);
         {rec_sat, left_sat, right_sat} = 3'h0;
         rdchk(7'h06, {2'h3, 5'h0, 3'h4 >> i, 6'h05});
         rdchk(7'h06, 16'hc005);
      end
      results();
   end
endmodule : tb
